// *** hdl/acs_sequencer.sv ***
// How it works
// R1 - Single-shot: one conversion per start, then back to idle.
// R2 - Done flag readable by polling once the conversion finished.
// R3 - Completion interrupts only when analogue interrupts are enabled.
// R4 - Start command begins converting; setup alone starts nothing.
// R5 - Continuous: conversions repeat back to back until stopped.
// R6 - Conversion lasts three sampling intervals plus 13 ADC clocks, no gaps.
// R7 - Continuous result held until the next conversion completes.
// R8 - Stop command halts continuous conversions.
// R9 - Accumulation runs 2, 4, 8 or 16 conversions, then stops.
// R10 - Accumulation start ignores the single/continuous setting.
// R11 - Accumulation done only after all conversions; result is raw sum.
// R12 - Stop aborts an accumulation run at any point.
// R13 - Buffer mode widens results to 16 bits and writes them by DMA.
// R14 - Buffer mode triggered by selected timer 0 to 4.
// R15 - Buffer length up to 2047 samples, start pointer, wrap option.
// R16 - Buffer mode applies its own input range selection.
// R17 - Each trigger converts every enabled source, one sample each.
// R18 - Sources stored in order: inputs 1-6, temperature, voltage.
// R19 - Wrap on: writing restarts at buffer start when full.
// R20 - Wrap off: when full, further samples discarded and flagged overflow.
// R21 - Half-full, full and overflow events, individually selectable.
// R22 - Dedicated stop command halts sample buffer operation.
// R23 - Capture event per conversion; accumulation event at final sum.
// R24 - Sampling interval 2/4/6/8 ADC clocks; ADC clock divided down.
// R25 - Starting a run clears done; new result sets it again.
module acs_sequencer (
	input wire logic clk,
	input wire logic reset,
	input wire acs_pkg::acs_gen_cfg_t analog_general_config,
	input wire acs_pkg::acs_setup_t converter_setup,
	input wire logic conversion_start_cmd,
	input wire logic conversion_stop_cmd,
	input wire logic accumulate_start_cmd,
	input wire logic [1:0] accum_count_sel,
	input wire logic sample_buffer_start_cmd,
	input wire logic sample_buffer_stop_cmd,
	input wire acs_pkg::acs_sb_cfg_t sample_buffer_cfg,
	input wire logic [acs_pkg::NUM_TIMERS-1:0] timer_repeat_tick,
	input wire logic [acs_pkg::RES_W-1:0] adc_data,
	input wire logic dma_ready,
	output logic [2:0] input_select,
	output logic range_double,
	output logic sampling,
	output logic converting,
	output logic conversion_done_poll,
	output logic [acs_pkg::SAMPLE_W-1:0] result_read,
	output acs_pkg::acs_irq_t analog_irq,
	output acs_pkg::acs_dma_t dma_write
);
	acs_pkg::acs_seq_t s;
	acs_pkg::acs_seq_t next_s;
	logic go;
	logic abort;
	logic adv;
	logic tick;
	logic conv_done;
	logic irq_en;

	assign irq_en = analog_general_config.irq_en;
	// Out-of-range timer numbers never trigger
	assign tick = (s.sb.timer_sel < 3'(acs_pkg::NUM_TIMERS)) && timer_repeat_tick[s.sb.timer_sel]; // [R14]

	acs_conv_timer u_timer (
		.clk(clk),
		.reset(reset),
		.start(go),
		.abort(abort),
		.clk_div(analog_general_config.clk_div),
		.si_sel(analog_general_config.si_sel),
		.busy(converting),
		.sampling(sampling),
		.done(conv_done)
	);

	always_comb begin
		next_s = s;
		go = 1'b0;
		abort = 1'b0;
		adv = 1'b0;
		next_s.irq = '0;
		// Converter output is asynchronous to clk
		next_s.sync1 = adc_data;
		next_s.sync2 = s.sync1;
		if (sample_buffer_stop_cmd && s.state != acs_pkg::ST_IDLE && s.state != acs_pkg::ST_CONV) begin
			next_s.sb_stop = 1'b1; // [R22]
		end
		case (s.state)
			acs_pkg::ST_IDLE: begin
				if (accumulate_start_cmd) begin
					next_s.mode = acs_pkg::MD_ACCUM; // [R10]
					next_s.acc_left = acs_pkg::acc_count(accum_count_sel); // [R9]
					next_s.acc_sum = '0;
					next_s.done = 1'b0; // [R25]
					go = 1'b1;
					next_s.state = acs_pkg::ST_CONV;
				end else if (conversion_start_cmd) begin
					next_s.mode = converter_setup.cont_mode ? acs_pkg::MD_CONT : acs_pkg::MD_SINGLE;
					next_s.done = 1'b0; // [R25]
					go = 1'b1; // [R4]
					next_s.state = acs_pkg::ST_CONV;
				end else if (sample_buffer_start_cmd) begin
					next_s.sb = sample_buffer_cfg; // [R15] [R16] [R21]
					next_s.idx = '0;
					next_s.full = 1'b0;
					next_s.sb_stop = 1'b0;
					next_s.state = acs_pkg::ST_SB_WAIT;
				end
			end
			acs_pkg::ST_CONV: begin
				if (conversion_stop_cmd) begin
					abort = 1'b1; // [R8] [R12]
					next_s.state = acs_pkg::ST_IDLE;
				end else if (conv_done) begin
					if (s.mode == acs_pkg::MD_ACCUM) begin
						// Raw sum; 16 x 1023 still fits in 16 bits
						next_s.acc_sum = s.acc_sum + acs_pkg::widen(s.sync2); // [R11]
						next_s.acc_left = s.acc_left - acs_pkg::ACC_W'(1);
						if (s.acc_left == acs_pkg::ACC_LAST) begin
							next_s.result = next_s.acc_sum; // [R11]
							next_s.done = 1'b1; // [R25]
							next_s.irq.accum = irq_en; // [R3] [R23]
							next_s.state = acs_pkg::ST_IDLE;
						end else begin
							go = 1'b1; // [R6]
						end
					end else begin
						next_s.result = acs_pkg::widen(s.sync2); // [R7]
						next_s.done = 1'b1; // [R2]
						next_s.irq.capture = irq_en; // [R3] [R23]
						if (s.mode == acs_pkg::MD_CONT) begin
							go = 1'b1; // [R5] [R6]
						end else begin
							next_s.state = acs_pkg::ST_IDLE; // [R1]
						end
					end
				end
			end
			acs_pkg::ST_SB_WAIT: begin
				if (s.sb_stop || sample_buffer_stop_cmd) begin
					next_s.state = acs_pkg::ST_IDLE; // [R22]
				end else if (tick && s.sb.src_map != '0) begin
					next_s.pend = s.sb.src_map; // [R17]
					next_s.ch = acs_pkg::first_src(s.sb.src_map); // [R18]
					go = 1'b1;
					next_s.state = acs_pkg::ST_SB_CONV;
				end
			end
			acs_pkg::ST_SB_CONV: begin
				if (s.sb_stop || sample_buffer_stop_cmd) begin
					abort = 1'b1; // [R22]
					next_s.state = acs_pkg::ST_IDLE;
				end else if (conv_done) begin
					next_s.pend[s.ch] = 1'b0;
					if (s.full && !s.sb.wrap_en) begin
						next_s.irq.ovf = irq_en && s.sb.irq_ovf; // [R20] [R21]
						adv = 1'b1;
					end else begin
						next_s.dma.valid = 1'b1; // [R13]
						next_s.dma.addr = s.sb.start_ptr + acs_pkg::ADDR_W'(s.idx); // [R15]
						next_s.dma.data = acs_pkg::widen(s.sync2); // [R13]
						next_s.state = acs_pkg::ST_SB_WRITE;
					end
				end
			end
			acs_pkg::ST_SB_WRITE: begin
				// A write in flight always completes; a stop takes effect after it
				if (dma_ready) begin
					next_s.dma.valid = 1'b0;
					next_s.idx = s.idx + acs_pkg::LEN_W'(1);
					if (s.idx + acs_pkg::LEN_W'(1) == (s.sb.len >> 1)) begin
						next_s.irq.half = irq_en && s.sb.irq_half; // [R21]
					end
					if (s.idx + acs_pkg::LEN_W'(1) == s.sb.len) begin
						next_s.irq.full = irq_en && s.sb.irq_full; // [R21]
						if (s.sb.wrap_en) begin
							next_s.idx = '0; // [R19]
						end else begin
							next_s.full = 1'b1; // [R20]
						end
					end
					adv = 1'b1;
				end
			end
			default: begin
				next_s.state = acs_pkg::ST_IDLE;
			end
		endcase
		if (adv) begin
			if (next_s.sb_stop) begin
				next_s.state = acs_pkg::ST_IDLE; // [R22]
			end else if (next_s.pend != '0) begin
				next_s.ch = acs_pkg::first_src(next_s.pend); // [R17] [R18]
				go = 1'b1;
				next_s.state = acs_pkg::ST_SB_CONV;
			end else begin
				next_s.state = acs_pkg::ST_SB_WAIT;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= acs_pkg::SEQ_RST;
		end else begin
			s <= next_s;
		end
	end

	logic in_sb;
	assign in_sb = s.state == acs_pkg::ST_SB_WAIT || s.state == acs_pkg::ST_SB_CONV || s.state == acs_pkg::ST_SB_WRITE;
	assign input_select = in_sb ? s.ch : converter_setup.input_sel;
	assign range_double = in_sb ? s.sb.range_double : converter_setup.range_double; // [R16]
	assign conversion_done_poll = s.done; // [R2]
	assign result_read = s.result;
	assign analog_irq = s.irq;
	assign dma_write = s.dma;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_conv_end;
		s.state == acs_pkg::ST_CONV && conv_done && !conversion_stop_cmd;
	endsequence

	sequence s_idle_start;
		s.state == acs_pkg::ST_IDLE && !accumulate_start_cmd && conversion_start_cmd;
	endsequence

	property p_single_stops;
		s_conv_end ##0 s.mode == acs_pkg::MD_SINGLE |=> s.state == acs_pkg::ST_IDLE && !converting;
	endproperty
	a_single_stops: assert property (p_single_stops) else $error("single shot did not stop"); // [R1]

	property p_done_result;
		s_conv_end ##0 s.mode != acs_pkg::MD_ACCUM |=>
			conversion_done_poll && result_read == acs_pkg::widen($past(s.sync2));
	endproperty
	a_done_result: assert property (p_done_result) else $error("result or done flag wrong"); // [R2] [R7]

	property p_irq_gate;
		!irq_en |=> !analog_irq.capture && !analog_irq.accum;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled"); // [R3]

	property p_start_clears;
		s_idle_start |=> !conversion_done_poll && converting && s.state == acs_pkg::ST_CONV;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("start did not clear done"); // [R4] [R25]

	property p_cont_repeat;
		s_conv_end ##0 s.mode == acs_pkg::MD_CONT |=> converting && s.state == acs_pkg::ST_CONV;
	endproperty
	a_cont_repeat: assert property (p_cont_repeat) else $error("continuous did not restart"); // [R5] [R6]

	property p_stop;
		s.state == acs_pkg::ST_CONV && conversion_stop_cmd |=> s.state == acs_pkg::ST_IDLE && !converting;
	endproperty
	a_stop: assert property (p_stop) else $error("stop ignored"); // [R8] [R12]

	property p_accum_wait;
		s_conv_end ##0 s.mode == acs_pkg::MD_ACCUM && s.acc_left != acs_pkg::ACC_LAST |=>
			!analog_irq.accum && !conversion_done_poll && $stable(result_read);
	endproperty
	a_accum_wait: assert property (p_accum_wait) else $error("accumulation ended early"); // [R11]

	property p_wrap;
		s.state == acs_pkg::ST_SB_WRITE && dma_ready && s.sb.wrap_en && s.idx + acs_pkg::LEN_W'(1) == s.sb.len
			|=> s.idx == '0 && !s.full;
	endproperty
	a_wrap: assert property (p_wrap) else $error("buffer did not wrap"); // [R19]

	property p_ovf;
		analog_irq.ovf |-> !dma_write.valid && $past(s.full);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow sample was written"); // [R20]

	property p_order;
		s.state == acs_pkg::ST_SB_CONV && conv_done |->
			(s.pend & ((8'h01 << s.ch) - 8'h01)) == 8'h00 && s.pend[s.ch];
	endproperty
	a_order: assert property (p_order) else $error("source order broken"); // [R18]

	sequence s_write_wait;
		s.state == acs_pkg::ST_SB_WRITE && !dma_ready;
	endsequence

	sequence s_sb_trigger;
		s.state == acs_pkg::ST_SB_WAIT && tick && s.sb.src_map != '0 && !s.sb_stop && !sample_buffer_stop_cmd;
	endsequence

	sequence s_accum_last;
		s_conv_end ##0 s.mode == acs_pkg::MD_ACCUM && s.acc_left == acs_pkg::ACC_LAST;
	endsequence

	// Sink may stall for many cycles; the request must not move meanwhile
	property p_dma_hold;
		s_write_wait |=> dma_write.valid && $stable(dma_write);
	endproperty
	a_dma_hold: assert property (p_dma_hold) else $error("dma request changed before accept"); // [R13]

	property p_accum_final;
		s_accum_last |=> conversion_done_poll && analog_irq.accum == $past(irq_en) && !converting;
	endproperty
	a_accum_final: assert property (p_accum_final) else $error("accumulation end wrong"); // [R9] [R11] [R23]

	property p_accum_mode;
		s.state == acs_pkg::ST_IDLE && accumulate_start_cmd |=> s.mode == acs_pkg::MD_ACCUM && converting;
	endproperty
	a_accum_mode: assert property (p_accum_mode) else $error("accumulation start wrong mode"); // [R10]

	property p_idle_quiet;
		s.state == acs_pkg::ST_IDLE && !accumulate_start_cmd && !conversion_start_cmd |=> !converting;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("conversion without start"); // [R1] [R4]

	property p_sb_trigger;
		s_sb_trigger |=> s.state == acs_pkg::ST_SB_CONV && converting;
	endproperty
	a_sb_trigger: assert property (p_sb_trigger) else $error("timer trigger ignored"); // [R14] [R17]

	property p_sb_stop;
		s.state == acs_pkg::ST_SB_WAIT && sample_buffer_stop_cmd |=> s.state == acs_pkg::ST_IDLE && !converting;
	endproperty
	a_sb_stop: assert property (p_sb_stop) else $error("buffer stop ignored"); // [R22]

	property p_ovf_nowrap;
		analog_irq.ovf |-> !s.sb.wrap_en && s.full;
	endproperty
	a_ovf_nowrap: assert property (p_ovf_nowrap) else $error("overflow with wrap on"); // [R21]

	// Overflow and discard go together: a dropped sample never reaches the sink
	property p_discard;
		s.state == acs_pkg::ST_SB_CONV && conv_done && s.full && !s.sb.wrap_en
			&& !s.sb_stop && !sample_buffer_stop_cmd |=> !dma_write.valid;
	endproperty
	a_discard: assert property (p_discard) else $error("sample written into full buffer"); // [R20]

	property p_full_event;
		s.state == acs_pkg::ST_SB_WRITE && dma_ready && s.idx + acs_pkg::LEN_W'(1) == s.sb.len
			|=> analog_irq.full == ($past(irq_en) && s.sb.irq_full);
	endproperty
	a_full_event: assert property (p_full_event) else $error("full event wrong"); // [R21]

	property p_half_event;
		s.state == acs_pkg::ST_SB_WRITE && dma_ready && s.idx + acs_pkg::LEN_W'(1) == (s.sb.len >> 1)
			|=> analog_irq.half == ($past(irq_en) && s.sb.irq_half);
	endproperty
	a_half_event: assert property (p_half_event) else $error("half event wrong"); // [R21]
endmodule

// *** common/acs_pkg.sv ***
package acs_pkg;
	localparam int RES_W = 10;
	localparam int SAMPLE_W = 16;
	// 11-bit length: 2047 samples is the largest buffer
	localparam int LEN_W = 11;
	localparam int ADDR_W = 16;
	localparam int NUM_SRC = 8;
	localparam int NUM_TIMERS = 5;
	localparam int DIV_W = 8;
	localparam int PER_W = 6;
	localparam int ACC_W = 5;
	localparam int SI_FACTOR = 3;
	localparam int SI_STEP = 2;
	localparam int CONV_TAIL = 13;
	localparam logic [ACC_W-1:0] ACC_LAST = 5'h01;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CONV = 3'h1,
		ST_SB_WAIT = 3'h3,
		ST_SB_CONV = 3'h2,
		ST_SB_WRITE = 3'h6
	} acs_state_t;

	typedef enum logic [1:0] {
		MD_SINGLE = 2'h0,
		MD_CONT = 2'h1,
		MD_ACCUM = 2'h2
	} acs_mode_t;

	typedef struct packed {
		logic irq_en;
		logic [DIV_W-1:0] clk_div;
		logic [1:0] si_sel;
	} acs_gen_cfg_t;

	typedef struct packed {
		logic cont_mode;
		logic range_double;
		logic [2:0] input_sel;
	} acs_setup_t;

	typedef struct packed {
		logic [2:0] timer_sel;
		logic range_double;
		logic [NUM_SRC-1:0] src_map;
		logic [ADDR_W-1:0] start_ptr;
		logic [LEN_W-1:0] len;
		logic wrap_en;
		logic irq_half;
		logic irq_full;
		logic irq_ovf;
	} acs_sb_cfg_t;

	typedef struct packed {
		logic capture;
		logic accum;
		logic half;
		logic full;
		logic ovf;
	} acs_irq_t;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [SAMPLE_W-1:0] data;
	} acs_dma_t;

	typedef struct packed {
		acs_state_t state;
		acs_mode_t mode;
		logic [ACC_W-1:0] acc_left;
		logic [SAMPLE_W-1:0] acc_sum;
		logic [SAMPLE_W-1:0] result;
		logic done;
		acs_irq_t irq;
		acs_sb_cfg_t sb;
		logic [NUM_SRC-1:0] pend;
		logic [2:0] ch;
		logic [LEN_W-1:0] idx;
		logic full;
		logic sb_stop;
		acs_dma_t dma;
		logic [RES_W-1:0] sync1;
		logic [RES_W-1:0] sync2;
	} acs_seq_t;

	typedef struct packed {
		logic [DIV_W-1:0] pre;
		logic [PER_W-1:0] per;
		logic [PER_W-1:0] len;
		logic busy;
	} acs_tmr_t;

	localparam acs_seq_t SEQ_RST = '0;
	localparam acs_tmr_t TMR_RST = '0;

	function automatic logic [PER_W-1:0] conv_periods(input logic [1:0] si_sel);
		conv_periods = PER_W'(SI_FACTOR * SI_STEP * (int'(si_sel) + 1) + CONV_TAIL);
	endfunction

	function automatic logic [SAMPLE_W-1:0] widen(input logic [RES_W-1:0] d);
		widen = {{(SAMPLE_W - RES_W){1'b0}}, d};
	endfunction

	function automatic logic [ACC_W-1:0] acc_count(input logic [1:0] sel);
		acc_count = ACC_W'(2 << sel);
	endfunction

	function automatic logic [2:0] first_src(input logic [NUM_SRC-1:0] map);
		first_src = 3'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (map[i]) begin
				first_src = 3'(i);
			end
		end
	endfunction
endpackage

// *** hdl/acs_conv_timer.sv ***
module acs_conv_timer (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic abort,
	input wire logic [acs_pkg::DIV_W-1:0] clk_div,
	input wire logic [1:0] si_sel,
	output logic busy,
	output logic sampling,
	output logic done
);
	acs_pkg::acs_tmr_t s;
	acs_pkg::acs_tmr_t next_s;
	logic [15:0] elapsed;
	logic last_tick;

	// Done marks the last busy cycle, so a restart in that cycle leaves no gap
	assign last_tick = (s.pre == clk_div) && (s.per == s.len - acs_pkg::PER_W'(1));

	always_comb begin
		next_s = s;
		if (start) begin
			next_s.busy = 1'b1;
			next_s.pre = '0;
			next_s.per = '0;
			next_s.len = acs_pkg::conv_periods(si_sel); // [R6] [R24]
		end else if (abort) begin
			next_s.busy = 1'b0;
		end else if (s.busy) begin
			if (s.pre == clk_div) begin // [R24]
				next_s.pre = '0;
				if (last_tick) begin
					next_s.busy = 1'b0;
				end else begin
					next_s.per = s.per + acs_pkg::PER_W'(1);
				end
			end else begin
				next_s.pre = s.pre + acs_pkg::DIV_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= acs_pkg::TMR_RST;
		end else begin
			s <= next_s;
		end
	end

	assign busy = s.busy;
	assign done = s.busy && last_tick; // [R6]
	// Integration spans three sampling intervals before the fixed tail
	assign sampling = s.busy && (s.per < s.len - acs_pkg::PER_W'(acs_pkg::CONV_TAIL));

	always_ff @(posedge clk) begin
		if (reset) begin
			elapsed <= 16'h0000;
		end else if (start) begin
			elapsed <= 16'h0001;
		end else if (elapsed != 16'hFFFF) begin
			elapsed <= elapsed + 16'h0001;
		end
	end

	property p_conv_len;
		@(posedge clk) disable iff (reset)
		done |-> elapsed == 16'(s.len) * (16'(clk_div) + 16'h0001);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // [R6]
endmodule

// *** verification/acs_partner_model.sv ***
module acs_partner_model (
	input wire logic clk,
	input wire logic reset,
	input wire acs_pkg::acs_dma_t dma_write,
	output logic dma_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] stall;
	logic [15:0] addr_log [$];
	logic [15:0] data_log [$];
	// Ready one cycle in three, so a write that arrives in a stall cycle has to hold until ready
	assign dma_ready = (stall == 2'h2);
	always @(posedge clk) begin
		if (reset) begin
			stall <= 2'h0;
		end else begin
			stall <= (stall == 2'h2) ? 2'h0 : stall + 2'h1;
			if (dma_write.valid && dma_ready) begin
				addr_log.push_back(dma_write.addr);
				data_log.push_back(dma_write.data);
			end
		end
	end
endmodule

// *** verification/acs_sequencer_tb.sv ***
module acs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	acs_pkg::acs_gen_cfg_t gen = '0;
	acs_pkg::acs_setup_t setup = '0;
	acs_pkg::acs_sb_cfg_t sb = '0;
	logic start = 1'b0;
	logic stop = 1'b0;
	logic acc_start = 1'b0;
	logic sb_start = 1'b0;
	logic sb_stop = 1'b0;
	logic [1:0] acc_sel = 2'h0;
	logic [4:0] tick = 5'h00;
	logic [9:0] adc = 10'h000;
	logic bump = 1'b0;
	logic ready;
	logic [2:0] in_sel;
	logic rng;
	logic conv;
	logic smp;
	logic done;
	logic [15:0] res;
	acs_pkg::acs_irq_t irq;
	acs_pkg::acs_dma_t dma;
	int err_total = 0;
	int check_count = 0;
	int cap_n = 0;
	int acc_n = 0;
	int half_n = 0;
	int full_n = 0;
	int ovf_n = 0;
	int smp_n = 0;

	acs_sequencer u_acs_sequencer (
		.clk(clk),
		.reset(reset),
		.analog_general_config(gen),
		.converter_setup(setup),
		.conversion_start_cmd(start),
		.conversion_stop_cmd(stop),
		.accumulate_start_cmd(acc_start),
		.accum_count_sel(acc_sel),
		.sample_buffer_start_cmd(sb_start),
		.sample_buffer_stop_cmd(sb_stop),
		.sample_buffer_cfg(sb),
		.timer_repeat_tick(tick),
		.adc_data(adc),
		.dma_ready(ready),
		.input_select(in_sel),
		.range_double(rng),
		.sampling(smp),
		.converting(conv),
		.conversion_done_poll(done),
		.result_read(res),
		.analog_irq(irq),
		.dma_write(dma)
	);

	acs_partner_model u_acs_partner_model (
		.clk(clk),
		.reset(reset),
		.dma_write(dma),
		.dma_ready(ready)
	);

	always #2.5 clk = ~clk;

	always @(posedge clk) begin
		cap_n += (irq.capture === 1'b1);
		acc_n += (irq.accum === 1'b1);
		half_n += (irq.half === 1'b1);
		full_n += (irq.full === 1'b1);
		ovf_n += (irq.ovf === 1'b1);
		smp_n += (smp === 1'b1);
		// New sample value per conversion so a stale result shows
		if (bump && irq.capture === 1'b1) begin
			adc <= adc + 10'h001;
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: start <= 1'b1;
			1: stop <= 1'b1;
			2: acc_start <= 1'b1;
			3: sb_start <= 1'b1;
			default: sb_stop <= 1'b1;
		endcase
		@(posedge clk);
		{start, stop, acc_start, sb_start, sb_stop} <= 5'h00;
	endtask

	task automatic tick2();
		@(posedge clk);
		tick <= 5'h04;
		@(posedge clk);
		tick <= 5'h00;
	endtask

	function automatic logic hit(input int sel);
		case (sel)
			0: hit = done;
			1: hit = conv;
			2: hit = dma.valid;
			default: hit = irq.capture;
		endcase
	endfunction

	task automatic wait_for(input int sel, input int lim, output int n);
		n = 0;
		while (n < lim) begin
			@(posedge clk);
			#1;
			n++;
			if (hit(sel) === 1'b1) break;
		end
	endtask

	function automatic int clen(input int d, input int s);
		clen = (3 * 2 * (s + 1) + 13) * (d + 1);
	endfunction

	task automatic t_single(input logic irq_on);
		int n;
		int c0;
		int s0;
		@(posedge clk);
		gen <= '{irq_en: irq_on, clk_div: 8'h00, si_sel: 2'h0};
		setup <= '{cont_mode: 1'b0, range_double: 1'b0, input_sel: 3'h2};
		adc <= 10'h155;
		cyc(3);
		#1 chk("idle_converting", 0, conv);
		c0 = cap_n;
		s0 = smp_n;
		pulse(0);
		#1 chk("converting", 1, conv);
		chk("done_cleared", 0, done);
		wait_for(0, 400, n);
		chk("conv_cycles", clen(0, 0), n);
		chk("sampling_cycles", 3 * 2, smp_n - s0);
		chk("result_read", 16'h0155, res);
		cyc(60);
		#1 chk("single_stays_idle", 0, conv);
		chk("capture_count", c0 + irq_on, cap_n);
	endtask

	task automatic t_cont();
		int n;
		int c1;
		@(posedge clk);
		gen <= '{irq_en: 1'b1, clk_div: 8'h01, si_sel: 2'h1};
		setup.cont_mode <= 1'b1;
		adc <= 10'h001;
		bump <= 1'b1;
		pulse(0);
		for (int i = 1; i <= 3; i++) begin
			wait_for(4, 400, n);
			chk("cont_period", clen(1, 1), n);
			chk("cont_result", i, res);
		end
		pulse(1);
		#1 chk("stopped", 0, conv);
		c1 = cap_n;
		bump <= 1'b0;
		cyc(120);
		chk("no_capture_after_stop", c1, cap_n);
	endtask

	task automatic t_accum();
		int n;
		int a0;
		@(posedge clk);
		gen <= '{irq_en: 1'b1, clk_div: 8'h00, si_sel: 2'h3};
		adc <= 10'h3FF;
		a0 = acc_n;
		// Continuous setup left on: accumulation must still stop
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			acc_sel <= s[1:0];
			pulse(2);
			wait_for(0, 1000, n);
			chk("accum_cycles", (2 << s) * clen(0, 3), n);
			chk("accum_sum", (2 << s) * 1023, res);
			cyc(40);
			#1 chk("accum_stopped", 0, conv);
		end
		chk("accum_events", a0 + 4, acc_n);
		pulse(2);
		cyc(50);
		pulse(1);
		#1 chk("accum_abort", 0, conv);
		cyc(400);
		chk("abort_no_event", a0 + 4, acc_n);
		chk("abort_result", 16'h3FF0, res);
	endtask

	task automatic t_buffer();
		int n;
		int h0;
		int f0;
		int o0;
		@(posedge clk);
		sb <= '{3'h2, 1'b1, 8'h81, 16'h1000, 11'h003, 1'b0, 1'b1, 1'b1, 1'b1};
		adc <= 10'h2A5;
		h0 = half_n;
		f0 = full_n;
		o0 = ovf_n;
		pulse(3);
		@(posedge clk);
		tick <= 5'h02;
		@(posedge clk);
		tick <= 5'h00;
		cyc(40);
		#1 chk("other_timer", 0, conv);
		tick2();
		wait_for(1, 5, n);
		chk("first_source", 0, in_sel);
		chk("sb_range", 1, rng);
		wait_for(2, 200, n);
		wait_for(1, 200, n);
		chk("second_source", 7, in_sel);
		cyc(150);
		tick2();
		cyc(150);
		chk("stored", 3, u_acs_partner_model.addr_log.size());
		for (int i = 0; i < 3; i++) begin
			chk("dma_addr", 16'h1000 + i, u_acs_partner_model.addr_log[i]);
			chk("dma_data", 16'h02A5, u_acs_partner_model.data_log[i]);
		end
		chk("half_events", h0 + 1, half_n);
		chk("full_events", f0 + 1, full_n);
		chk("ovf_events", o0 + 1, ovf_n);
		pulse(4);
		@(posedge clk);
		sb <= '{3'h2, 1'b0, 8'h01, 16'h2000, 11'h002, 1'b1, 1'b1, 1'b1, 1'b1};
		pulse(3);
		repeat (3) begin
			tick2();
			cyc(120);
		end
		chk("wrap_stored", 6, u_acs_partner_model.addr_log.size());
		chk("wrap_addr", 16'h2000, u_acs_partner_model.addr_log[5]);
		chk("wrap_no_ovf", o0 + 1, ovf_n);
		pulse(4);
		tick2();
		cyc(120);
		chk("sb_stopped", 6, u_acs_partner_model.addr_log.size());
	endtask

	task automatic final_report();
		if (err_total == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		cyc(20);
		reset <= 1'b0;
		t_single(1'b1);
		t_single(1'b0);
		t_cont();
		t_accum();
		t_buffer();
		final_report();
	end

	// Whole sequence needs well under half of this span
	initial begin
		cyc(20000);
		err_total++;
		final_report();
	end
endmodule
